// >>> pkg/vsmp_pkg.sv
// constants shared by the display unit and the processor-side host end
`default_nettype none
package vsmp_pkg;
	// ----------------------------------------
	// clocking
	// ----------------------------------------
	localparam int CLK_HZ = 50_000_000;
	localparam int CLK_NS = 20;
	localparam int IN_CLK_HZ = 3_500_000;
	localparam int CLK_PER_IN = CLK_HZ / IN_CLK_HZ;
	localparam int IN_PER_WIN = 4;
	// ----------------------------------------
	// raster geometry in windows and lines
	// ----------------------------------------
	localparam int WIN_PER_LINE = 56;
	localparam int H_ACT_START = 16;
	localparam int H_ACT_WIN = 40;
	localparam int HS_SHORT_WIN = 4;
	localparam int HS_LONG_WIN = 16;
	localparam int EXT_SAMPLE_WIN = 11;
	localparam int VS_LINES = 2;
	localparam int FIELD_60 = 262;
	localparam int FIELD_50 = 312;
	localparam int V_ACT_START = 20;
	localparam int V_ACT_60 = 210;
	localparam int V_ACT_50 = 250;
	// ----------------------------------------
	// display mode register and commands
	// ----------------------------------------
	localparam int R_DISP_EN = 0;
	localparam int R_BOX_EN = 1;
	localparam int R_FIELD_50 = 5;
	localparam int R_HS_LONG = 6;
	localparam logic [7:0] R_RESET = 8'h00;
	localparam logic [2:0] CMD_LOAD_R = 3'h5;
	localparam int BUSY_BIT = 7;
	// ----------------------------------------
	// processor bus timing
	// ----------------------------------------
	localparam int T_WE_NS = 200;
	localparam int E_CYC = (T_WE_NS + CLK_NS - 1) / CLK_NS;
	// ----------------------------------------
	// host register map
	// ----------------------------------------
	localparam logic [3:0] REG_CMD = 4'h0;
	localparam logic [3:0] REG_STAT = 4'h4;
	localparam int CMD_BA = 8;
	localparam int CMD_CT = 9;
	localparam int CMD_RW = 10;
	localparam int STAT_BUSY = 8;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SETUP = 2'b01,
		ST_STROBE = 2'b10,
		ST_HOLD = 2'b11
	} vsmp_host_st_t;
endpackage
`default_nettype wire

// >>> pkg/vsmp_bus_if.sv
// processor bus between the host end and the display unit
`timescale 1ns/10ps
`default_nettype none
interface vsmp_bus_if;
	logic cs_n;
	logic e;
	logic rw;
	logic b_a;
	logic c_t;
	logic [7:0] d_host;
	logic d_host_oe;
	logic [7:0] d_dev;
	logic d_dev_oe;
	logic [7:0] d_bus;
	// undriven bus floats high
	assign d_bus = d_dev_oe ? d_dev : (d_host_oe ? d_host : 8'hff);
	modport dev (input cs_n, e, rw, b_a, c_t, d_bus, output d_dev, d_dev_oe);
	modport host (output cs_n, e, rw, b_a, c_t, d_host, d_host_oe, input d_bus);
endinterface
`default_nettype wire

// >>> logic/vsmp_device.sv
// display unit end: video timing, sync pins and processor mailbox
// Functional notes
// - rgb low during all blanking
// - vertical sync low two lines per field
// - field length 262 or 312 lines
// - hsync short low or long high
// - boxing output active high
// - sample external sync in window 11
// - external sync fall resets line at end
// - system supplies 3.5 MHz input clock; here in_tick divides clk_i by 14 instead
// - request select low on high-register access
// - request select fall latches select, pends
// - restart holds hsync high until mode load
// - data drivers off except on reads
// - enable strobes mailbox transfers
// - chip select high ignores accesses
// - read/write low writes, high reads
// - half select picks low or high
// - command/transfer select marks mailbox contents
// - high write sets busy, service clears
// - status read returns busy on bit 7
//
// Decided for this implementation: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module vsmp_device (
	// clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// processor mailbox bus
	vsmp_bus_if.dev bus,
	// external pins
	input wire logic ext_vsync_in_i,
	input wire logic restart_n_i,
	// pixel stream from the character generator
	input wire logic [2:0] pix_rgb_i,
	input wire logic box_attr_i,
	input wire logic [15:0] xfer_rd_data_i,
	// video outputs
	output logic [2:0] rgb_o,
	output logic vsync_out_n_o,
	output logic hsync_out_o,
	output logic box_o,
	// mailbox service
	output logic request_select_n_o,
	output logic xfer_valid_o,
	output logic [15:0] xfer_data_o,
	output logic [7:0] mode_o
);
	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [1:0] vs_sync;
	logic [1:0] rs_sync;
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			vs_sync <= 2'h0;
			rs_sync <= 2'h3;
		end else begin
			vs_sync <= {vs_sync[0], ext_vsync_in_i};
			rs_sync <= {rs_sync[0], restart_n_i};
		end
	end

	// ----------------------------------------
	// window timing
	// ----------------------------------------
	logic [3:0] in_div;
	logic [1:0] sub;
	logic in_tick;
	logic win_tick;
	logic [5:0] win;
	logic line_end;
	assign in_tick = in_div == 4'(vsmp_pkg::CLK_PER_IN - 1);
	assign win_tick = in_tick && sub == 2'(vsmp_pkg::IN_PER_WIN - 1);
	assign line_end = win_tick && win == 6'(vsmp_pkg::WIN_PER_LINE - 1);
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			in_div <= 4'h0;
			sub <= 2'h0;
			win <= 6'h0;
		end else begin
			in_div <= in_tick ? 4'h0 : in_div + 4'h1;
			if (in_tick) begin
				sub <= sub + 2'h1;
			end
			if (line_end) begin
				win <= 6'h0;
			end else if (win_tick) begin
				win <= win + 6'h1;
			end
		end
	end

	// ----------------------------------------
	// line counter and external sync
	// ----------------------------------------
	logic [7:0] r_mode;
	logic [8:0] line;
	logic [8:0] field_len;
	logic [8:0] v_act;
	logic ext_held;
	logic resync;
	assign field_len = r_mode[vsmp_pkg::R_FIELD_50] ? 9'(vsmp_pkg::FIELD_50) :
		9'(vsmp_pkg::FIELD_60);
	assign v_act = r_mode[vsmp_pkg::R_FIELD_50] ? 9'(vsmp_pkg::V_ACT_50) :
		9'(vsmp_pkg::V_ACT_60);
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ext_held <= 1'b0;
			resync <= 1'b0;
		end else begin
			if (win_tick && win == 6'(vsmp_pkg::EXT_SAMPLE_WIN)) begin
				ext_held <= vs_sync[1];
				if (ext_held && !vs_sync[1]) begin
					resync <= 1'b1;
				end
			end else if (line_end) begin
				resync <= 1'b0;
			end
		end
	end
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			line <= 9'h0;
		end else if (line_end) begin
			if (resync) begin
				line <= 9'h0;
			end else if (line == field_len - 9'h1) begin
				line <= 9'h0;
			end else begin
				line <= line + 9'h1;
			end
		end
	end

	// ----------------------------------------
	// video outputs
	// ----------------------------------------
	logic h_act;
	logic v_act_now;
	logic shown;
	logic hs_hold;
	logic r_load;
	assign h_act = win >= 6'(vsmp_pkg::H_ACT_START) &&
		win < 6'(vsmp_pkg::H_ACT_START + vsmp_pkg::H_ACT_WIN);
	assign v_act_now = line >= 9'(vsmp_pkg::V_ACT_START) &&
		line < 9'(vsmp_pkg::V_ACT_START) + v_act;
	assign shown = h_act && v_act_now && r_mode[vsmp_pkg::R_DISP_EN];
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			hs_hold <= 1'b1;
		end else if (!rs_sync[1]) begin
			hs_hold <= 1'b1;
		end else if (r_load) begin
			hs_hold <= 1'b0;
		end
	end
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rgb_o <= 3'h0;
			box_o <= 1'b0;
			vsync_out_n_o <= 1'b1;
			hsync_out_o <= 1'b1;
		end else begin
			rgb_o <= shown ? pix_rgb_i : 3'h0;
			box_o <= shown && (!r_mode[vsmp_pkg::R_BOX_EN] || box_attr_i);
			vsync_out_n_o <= !(line < 9'(vsmp_pkg::VS_LINES));
			if (hs_hold) begin
				hsync_out_o <= 1'b1;
			end else if (r_mode[vsmp_pkg::R_HS_LONG]) begin
				hsync_out_o <= win < 6'(vsmp_pkg::HS_LONG_WIN);
			end else begin
				hsync_out_o <= !(win < 6'(vsmp_pkg::HS_SHORT_WIN));
			end
		end
	end

	// ----------------------------------------
	// processor mailbox
	// ----------------------------------------
	logic e_q;
	logic sel;
	logic e_rise;
	logic wr;
	logic hi_req;
	logic req_q;
	logic pend;
	logic pend_cmd;
	logic pend_rd;
	logic svc;
	logic busy;
	logic [7:0] mb_lo;
	logic [7:0] mb_hi;
	assign sel = !bus.cs_n;
	assign e_rise = bus.e && !e_q && sel;
	assign wr = e_rise && !bus.rw;
	assign hi_req = sel && bus.e && bus.b_a && !(bus.c_t && bus.rw);
	assign svc = pend && win_tick;
	assign mode_o = r_mode;
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			e_q <= 1'b0;
			req_q <= 1'b1;
			request_select_n_o <= 1'b1;
		end else begin
			e_q <= bus.e;
			request_select_n_o <= !hi_req;
			req_q <= request_select_n_o;
		end
	end
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pend <= 1'b0;
			pend_cmd <= 1'b0;
			pend_rd <= 1'b0;
		end else if (req_q && !request_select_n_o) begin
			pend <= 1'b1;
			pend_cmd <= bus.c_t;
			pend_rd <= bus.rw;
		end else if (svc) begin
			pend <= 1'b0;
		end
	end
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			busy <= 1'b0;
		end else if (e_rise && hi_req) begin
			busy <= 1'b1;
		end else if (svc) begin
			busy <= 1'b0;
		end
	end
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			mb_lo <= 8'h0;
			mb_hi <= 8'h0;
		end else if (wr) begin
			if (bus.b_a) begin
				mb_hi <= bus.d_bus;
			end else begin
				mb_lo <= bus.d_bus;
			end
		end else if (svc && !pend_cmd && pend_rd) begin
			{mb_hi, mb_lo} <= xfer_rd_data_i;
		end
	end
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			r_mode <= vsmp_pkg::R_RESET;
			r_load <= 1'b0;
			xfer_valid_o <= 1'b0;
			xfer_data_o <= 16'h0;
		end else begin
			r_load <= svc && pend_cmd && mb_hi[7:5] == vsmp_pkg::CMD_LOAD_R;
			xfer_valid_o <= svc && !pend_cmd && !pend_rd;
			if (svc && !pend_cmd && !pend_rd) begin
				xfer_data_o <= {mb_hi, mb_lo};
			end
			if (svc && pend_cmd && mb_hi[7:5] == vsmp_pkg::CMD_LOAD_R) begin
				r_mode <= mb_lo;
			end
		end
	end
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			bus.d_dev <= 8'h0;
			bus.d_dev_oe <= 1'b0;
		end else begin
			bus.d_dev_oe <= sel && bus.e && bus.rw;
			if (bus.c_t && !bus.b_a) begin
				bus.d_dev <= 8'(busy) << vsmp_pkg::BUSY_BIT;
			end else if (bus.c_t) begin
				bus.d_dev <= 8'h0;
			end else begin
				bus.d_dev <= bus.b_a ? mb_hi : mb_lo;
			end
		end
	end
endmodule // vsmp_device
`default_nettype wire

// >>> logic/vsmp_host.sv
// processor end: AXI4-Lite orders turned into mailbox bus cycles
`timescale 1ns/10ps
`default_nettype none
module vsmp_host (
	// clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// AXI4-Lite write
	input wire logic [3:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	// AXI4-Lite read
	input wire logic [3:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	// mailbox bus
	vsmp_bus_if.host bus
);
	// ----------------------------------------
	// write channel
	// ----------------------------------------
	vsmp_pkg::vsmp_host_st_t st;
	logic aw_got;
	logic w_got;
	logic [3:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic start;
	logic [3:0] cnt;
	logic [7:0] rd_byte;
	assign s_axi_awready_o = !aw_got && !s_axi_bvalid_o;
	assign s_axi_wready_o = !w_got && !s_axi_bvalid_o;
	// orders while a cycle runs are dropped
	assign start = aw_got && w_got && !s_axi_bvalid_o && aw_addr == vsmp_pkg::REG_CMD &&
		w_strb[1:0] == 2'h3 && st == vsmp_pkg::ST_IDLE;
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			aw_got <= 1'b0;
			w_got <= 1'b0;
			aw_addr <= 4'h0;
			w_data <= 32'h0;
			w_strb <= 4'h0;
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o <= vsmp_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid_i && s_axi_awready_o) begin
				aw_got <= 1'b1;
				aw_addr <= s_axi_awaddr_i;
			end
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				w_got <= 1'b1;
				w_data <= s_axi_wdata_i;
				w_strb <= s_axi_wstrb_i;
			end
			if (aw_got && w_got && !s_axi_bvalid_o) begin
				aw_got <= 1'b0;
				w_got <= 1'b0;
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o <= (aw_addr == vsmp_pkg::REG_CMD ||
					aw_addr == vsmp_pkg::REG_STAT) ? vsmp_pkg::RESP_OKAY :
					vsmp_pkg::RESP_SLVERR;
			end else if (s_axi_bready_i) begin
				s_axi_bvalid_o <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// read channel
	// ----------------------------------------
	assign s_axi_arready_o = !s_axi_rvalid_o;
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o <= 32'h0;
			s_axi_rresp_o <= vsmp_pkg::RESP_OKAY;
		end else if (s_axi_arvalid_i && s_axi_arready_o) begin
			s_axi_rvalid_o <= 1'b1;
			s_axi_rresp_o <= vsmp_pkg::RESP_OKAY;
			s_axi_rdata_o <= 32'h0;
			if (s_axi_araddr_i == vsmp_pkg::REG_STAT) begin
				s_axi_rdata_o <= {23'h0, st != vsmp_pkg::ST_IDLE, rd_byte};
			end else if (s_axi_araddr_i != vsmp_pkg::REG_CMD) begin
				s_axi_rresp_o <= vsmp_pkg::RESP_SLVERR;
			end
		end else if (s_axi_rready_i) begin
			s_axi_rvalid_o <= 1'b0;
		end
	end

	// ----------------------------------------
	// mailbox bus cycle
	// ----------------------------------------
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			st <= vsmp_pkg::ST_IDLE;
			cnt <= 4'h0;
			rd_byte <= 8'h0;
			bus.cs_n <= 1'b1;
			bus.e <= 1'b0;
			bus.rw <= 1'b1;
			bus.b_a <= 1'b0;
			bus.c_t <= 1'b0;
			bus.d_host <= 8'h0;
			bus.d_host_oe <= 1'b0;
		end else begin
			unique case (st)
				vsmp_pkg::ST_IDLE: begin
					if (start) begin
						st <= vsmp_pkg::ST_SETUP;
						bus.cs_n <= 1'b0;
						bus.rw <= w_data[vsmp_pkg::CMD_RW];
						bus.b_a <= w_data[vsmp_pkg::CMD_BA];
						bus.c_t <= w_data[vsmp_pkg::CMD_CT];
						bus.d_host <= w_data[7:0];
						bus.d_host_oe <= !w_data[vsmp_pkg::CMD_RW];
					end
				end
				vsmp_pkg::ST_SETUP: begin
					// address set up a cycle before enable
					st <= vsmp_pkg::ST_STROBE;
					bus.e <= 1'b1;
					cnt <= 4'h0;
				end
				vsmp_pkg::ST_STROBE: begin
					cnt <= cnt + 4'h1;
					if (cnt == 4'(vsmp_pkg::E_CYC - 1)) begin
						st <= vsmp_pkg::ST_HOLD;
						bus.e <= 1'b0;
						if (bus.rw) begin
							rd_byte <= bus.d_bus;
						end
					end
				end
				vsmp_pkg::ST_HOLD: begin
					st <= vsmp_pkg::ST_IDLE;
					bus.cs_n <= 1'b1;
					bus.d_host_oe <= 1'b0;
				end
			endcase
		end
	end
endmodule // vsmp_host
`default_nettype wire

// >>> tb/vsmp_props.sv
// concurrent checks on the mailbox bus and the video pins
`timescale 1ns/10ps
`default_nettype none
module vsmp_props (
	// clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// mailbox bus
	input wire logic cs_n,
	input wire logic e,
	input wire logic rw,
	input wire logic b_a,
	input wire logic c_t,
	input wire logic d_dev_oe,
	// device pins
	input wire logic restart_n_i,
	input wire logic [2:0] rgb_o,
	input wire logic vsync_out_n_o,
	input wire logic hsync_out_o,
	input wire logic box_o,
	input wire logic request_select_n_o,
	input wire logic [7:0] mode_o
);
	// ----------------------------------------
	// pulse width counters
	// ----------------------------------------
	int vs_cnt;
	int hs_cnt;
	logic hs_ok;
	// the first pulse after a hold may be cut short, so it is not judged
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			vs_cnt <= 0;
			hs_cnt <= 0;
			hs_ok <= 1'b0;
		end else begin
			vs_cnt <= vsync_out_n_o ? 0 : vs_cnt + 1;
			hs_cnt <= hsync_out_o ? 0 : hs_cnt + 1;
			hs_ok <= restart_n_i && (hs_ok || (hsync_out_o && hs_cnt != 0));
		end
	end
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (sys_rst_i);
	AST_BLANK: assert property ((!vsync_out_n_o && !$past(vsync_out_n_o))
		|| (!hsync_out_o && !$past(hsync_out_o) && !mode_o[6])
		|-> rgb_o == 3'h0 && !box_o) else $error("colour or box during sync");
	AST_VS_WIDTH: assert property ($rose(vsync_out_n_o)
		|-> vs_cnt inside {[6271:6272]}) else $error("vertical sync width wrong");
	AST_HS_SHORT: assert property ($rose(hsync_out_o) && hs_ok && !mode_o[6]
		|-> hs_cnt == 224) else $error("short line sync width wrong");
	AST_RESTART: assert property (!restart_n_i [*5] |-> hsync_out_o)
		else $error("line sync not held high in restart");
	AST_RD_DRIVE: assert property (d_dev_oe |-> $past(!cs_n && e && rw))
		else $error("data driven outside a read");
	AST_SEL_CAUSE: assert property (!request_select_n_o
		|-> $past(!cs_n && e && b_a && !(c_t && rw))) else $error("select without high access");
	AST_SEL_FOLLOW: assert property (!cs_n && e && b_a && !rw |=> !request_select_n_o)
		else $error("high write raised no select");
	AST_CS_IGNORE: assert property (cs_n |=> !d_dev_oe && request_select_n_o)
		else $error("deselected access acted on");
	AST_EN_GATE: assert property (!e |=> !d_dev_oe)
		else $error("data driven without enable");
	AST_E_PULSE: assert property ($rose(e) |-> e [*8] ##1 e ##1 e ##1 !e)
		else $error("enable pulse not ten cycles");
	AST_WR_NODRV: assert property (!cs_n && e && !rw |=> !d_dev_oe)
		else $error("data driven on a write");
endmodule // vsmp_props
`default_nettype wire

// >>> tb/vsmp_tb_top.sv
// bench: processor orders through both ends, video pins watched
`timescale 1ns/10ps
`default_nettype none
module vsmp_tb_top;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	localparam int WIN = vsmp_pkg::IN_PER_WIN * vsmp_pkg::CLK_PER_IN;
	localparam int LINE = WIN * vsmp_pkg::WIN_PER_LINE;
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [3:0] awaddr = 4'h0;
	logic [3:0] araddr = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic ext_vs = 1'b0;
	logic restart_n = 1'b1;
	logic awready, wready, bvalid, arready, rvalid, vs_n, hs, box, rsel_n, rsel_q, xv;
	logic [1:0] bresp, rresp, resp;
	logic [31:0] rdata, got;
	logic [2:0] rgb;
	logic [15:0] xd, xcap;
	logic [7:0] mode;
	int n_fail = 0;
	int comparisons = 0;
	int falls = 0;
	int t;
	always #(vsmp_pkg::CLK_NS / 2) clk_i = ~clk_i;
	vsmp_bus_if bus ();
	vsmp_host u_vsmp_host (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .s_axi_awaddr_i(awaddr),
		.s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
		.s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
		.s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
		.s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
		.s_axi_rready_i(rready), .bus(bus));
	vsmp_device u_vsmp_device (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus(bus),
		.ext_vsync_in_i(ext_vs), .restart_n_i(restart_n), .pix_rgb_i(3'h6), .box_attr_i(1'b1),
		.xfer_rd_data_i(16'h5aa5), .rgb_o(rgb), .vsync_out_n_o(vs_n), .hsync_out_o(hs),
		.box_o(box), .request_select_n_o(rsel_n), .xfer_valid_o(xv), .xfer_data_o(xd),
		.mode_o(mode));
	vsmp_props u_vsmp_props (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .cs_n(bus.cs_n),
		.e(bus.e), .rw(bus.rw), .b_a(bus.b_a), .c_t(bus.c_t), .d_dev_oe(bus.d_dev_oe),
		.restart_n_i(restart_n), .rgb_o(rgb), .vsync_out_n_o(vs_n), .hsync_out_o(hs),
		.box_o(box), .request_select_n_o(rsel_n), .mode_o(mode));
	// select falls and transfer words seen on the pins
	always @(posedge clk_i) begin
		rsel_q <= rsel_n;
		if (rsel_q === 1'b1 && rsel_n === 1'b0) falls++;
		if (xv === 1'b1) xcap <= xd;
	end
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic results();
		$display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic tmo();
		n_fail++;
		$display("MISMATCH t=%0t wait ran out", $time);
		results();
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		comparisons++;
		if (g !== x) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge clk_i);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid === 1'b1) begin
				resp = bresp;
				bready <= 1'b0;
				break;
			end
		end
		if (n == 100) tmo();
	endtask
	task automatic axi_rd(input logic [3:0] a);
		int n;
		@(posedge clk_i);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge clk_i);
			if (arready) arvalid <= 1'b0;
			if (rvalid === 1'b1) begin
				got = rdata;
				resp = rresp;
				rready <= 1'b0;
				break;
			end
		end
		if (n == 100) tmo();
	endtask
	// one mailbox cycle {rw, c_t, b_a, byte}, then wait until the bus is idle
	task automatic mb(input logic [10:0] w);
		int n;
		axi_wr(vsmp_pkg::REG_CMD, {21'h0, w});
		for (n = 0; n < 50; n++) begin
			axi_rd(vsmp_pkg::REG_STAT);
			if (got[vsmp_pkg::STAT_BUSY] === 1'b0) break;
		end
		if (n == 50) tmo();
	endtask
	task automatic till(input int s, input logic lvl, input int lim);
		for (t = 0; t < lim; t++) begin
			@(posedge clk_i);
			if ((s == 0 ? vs_n : (s == 1 ? hs : rgb == 3'h6)) === lvl) return;
		end
		tmo();
	endtask
	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial begin
		#(100000 * vsmp_pkg::CLK_NS);
		tmo();
	end
	initial begin
		repeat (4) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		till(0, 1'b0, 20);
		chk(32'(hs), 1);
		mb(11'h201);
		chk(falls, 0);
		mb(11'h3a0);
		chk(falls, 1);
		// service waits for the next window tick
		repeat (WIN + 2) @(posedge clk_i);
		chk(mode, 8'h01);
		mb(11'h600);
		chk(got[7:0], 8'h00);
		mb(11'h700);
		chk({got[7:0], 8'(falls)}, 16'h0001);
		mb(11'h034);
		mb(11'h112);
		repeat (WIN + 2) @(posedge clk_i);
		chk(xcap, 16'h1234);
		mb(11'h500);
		repeat (WIN + 2) @(posedge clk_i);
		mb(11'h400);
		chk(got[7:0], 8'ha5);
		mb(11'h500);
		chk({got[7:0], 8'(falls)}, 16'h5a04);
		axi_rd(4'h8);
		chk(resp, vsmp_pkg::RESP_SLVERR);
		axi_wr(4'hc, 32'h0);
		chk(resp, vsmp_pkg::RESP_SLVERR);
		till(2, 1'b1, 25 * LINE);
		repeat (2) @(posedge clk_i);
		chk(32'(box), 1);
		ext_vs <= 1'b1;
		repeat (2 * LINE) @(posedge clk_i);
		ext_vs <= 1'b0;
		till(0, 1'b0, 3 * LINE);
		chk(32'(t >= 44 * WIN), 1);
		chk(t, 2 * LINE - vsmp_pkg::H_ACT_START * WIN - 3);
		mb(11'h241);
		mb(11'h3a0);
		repeat (WIN + 2) @(posedge clk_i);
		till(1, 1'b0, LINE);
		till(1, 1'b1, LINE);
		till(1, 1'b0, LINE);
		chk(t, vsmp_pkg::HS_LONG_WIN * WIN - 1);
		// just past a window edge, so the high command is still unserviced
		mb(11'h300);
		mb(11'h600);
		chk(got[7:0], 8'h80);
		repeat (WIN) @(posedge clk_i);
		mb(11'h600);
		chk(got[7:0], 8'h00);
		restart_n <= 1'b0;
		repeat (10) @(posedge clk_i);
		restart_n <= 1'b1;
		for (t = 0; t < 2 * LINE && hs === 1'b1; t++) @(posedge clk_i);
		chk(t, 2 * LINE);
		mb(11'h3a0);
		till(1, 1'b0, LINE);
		results();
	end
endmodule // vsmp_tb_top
`default_nettype wire
